/* File: hdl/vol_pkg.sv */
package vol_pkg;
  localparam int GAIN_W = 7;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_CH = 6;

  localparam logic [7:0] ADC_GAIN_OFS = 8'h01;
  localparam logic [7:0] DAC_GAIN_OFS = 8'h02;
  localparam logic [7:0] BYP_GAIN_OFS = 8'h03;
  localparam logic [7:0] RAMP_CTRL_OFS = 8'h04;

  localparam int LEFT_MUTE_BIT = 15;
  localparam int LEFT_CODE_LSB = 8;
  localparam int RIGHT_MUTE_BIT = 7;
  localparam int RIGHT_CODE_LSB = 0;
  localparam int HALF_RATE_BIT = 1;
  localparam int DONE_BIT = 0;

  localparam logic [6:0] ADC_MIN_CODE = 7'h07;
  localparam logic [6:0] ADC_UNITY_CODE = 7'h57;
  localparam logic [6:0] DAC_MIN_CODE = 7'h00;
  localparam logic [6:0] DAC_FULL_CODE = 7'h7f;
  localparam logic [6:0] BYP_MIN_CODE = 7'h20;
  localparam logic [6:0] BYP_UNITY_CODE = 7'h67;

  localparam logic [15:0] ADC_GAIN_RST = 16'hd7d7;
  localparam logic [15:0] DAC_GAIN_RST = 16'hffff;
  localparam logic [15:0] BYP_GAIN_RST = 16'he7e7;
  localparam logic HALF_RATE_RST = 1'b0;

  localparam int CLK_PERIOD_NS = 25;
  localparam int STEP_NORMAL_NS = 20000;
  localparam int STEP_HALF_NS = 40000;
  localparam int STEP_NORMAL_CYC = STEP_NORMAL_NS / CLK_PERIOD_NS;
  localparam int STEP_HALF_CYC = STEP_HALF_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = 11;
endpackage

/* File: hdl/step_if.sv */
interface step_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

/* File: hdl/step_timer.sv */
module step_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic half_rate,
  step_if.src step
);
  logic [vol_pkg::STEP_CNT_W-1:0] cnt_q;
  logic [vol_pkg::STEP_CNT_W-1:0] cnt_d;
  logic [vol_pkg::STEP_CNT_W-1:0] last_cnt;
  logic wrap;
  logic tick_q;

  // half rate doubles the interval between gain updates
  assign last_cnt = half_rate ? vol_pkg::STEP_CNT_W'(vol_pkg::STEP_HALF_CYC - 1)
                              : vol_pkg::STEP_CNT_W'(vol_pkg::STEP_NORMAL_CYC - 1);
  assign wrap = (cnt_q >= last_cnt);
  assign cnt_d = wrap ? '0 : cnt_q + 1'b1;
  assign step.tick = tick_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end
endmodule // step_timer

/* File: hdl/softstep_channel.sv */
module softstep_channel #(
  parameter logic [6:0] MIN_CODE = 7'h00
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  step_if.dst step,
  input wire logic mute_req,
  input wire logic [6:0] code,
  output logic [6:0] applied_q,
  output logic muted_q,
  output logic settled_q
);
  logic mute_active;
  logic [6:0] target;
  logic [6:0] applied_d;

  // codes under the floor behave as a mute; the code itself is never touched
  assign mute_active = mute_req | (code < MIN_CODE);
  assign target = mute_active ? MIN_CODE : code;
  // one half-dB step per tick, never a jump
  assign applied_d = !step.tick ? applied_q :
                     (applied_q < target) ? applied_q + 7'h01 :
                     (applied_q > target) ? applied_q - 7'h01 : applied_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      applied_q <= MIN_CODE;
      muted_q <= 1'b1;
      settled_q <= 1'b1;
    end else if (ce) begin
      applied_q <= applied_d;
      // hard mute only once the floor is reached; unmute releases first
      muted_q <= mute_active & (applied_d == MIN_CODE);
      settled_q <= (applied_d == target);
    end
  end
endmodule // softstep_channel

/* File: hdl/audio_volume_mute_softstep.sv */
module audio_volume_mute_softstep (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [15:0] rd_data,
  output logic [41:0] applied_gain,
  output logic [5:0] channel_muted,
  output logic [19:0] dac_left_sample_out,
  output logic [19:0] dac_right_sample_out,
  output logic ramp_done_flag,
  input wire logic [19:0] dac_left_sample_in,
  input wire logic [19:0] dac_right_sample_in
);
  logic [15:0] adc_input_gain_q;
  logic [15:0] dac_digital_gain_q;
  logic [15:0] line_bypass_gain_q;
  logic ramp_half_rate_select_q;
  logic [15:0] rd_data_q;
  logic [19:0] dac_left_q;
  logic [19:0] dac_right_q;
  logic done_q;

  logic sel_adc;
  logic sel_dac;
  logic sel_byp;
  logic sel_ctrl;
  logic [15:0] ctrl_view;
  logic [15:0] rd_mux;
  logic [5:0] mute_req;
  logic [41:0] code_vec;
  logic [41:0] applied_vec;
  logic [5:0] muted_vec;
  logic [5:0] settled_vec;
  logic write_hit;
  logic write_hit_q;

  step_if step ();

  assign sel_adc = (addr == vol_pkg::ADC_GAIN_OFS);
  assign sel_dac = (addr == vol_pkg::DAC_GAIN_OFS);
  assign sel_byp = (addr == vol_pkg::BYP_GAIN_OFS);
  assign sel_ctrl = (addr == vol_pkg::RAMP_CTRL_OFS);
  // a gain write may move a target; settled flags trail it by two edges
  assign write_hit = wr_strobe & (sel_adc | sel_dac | sel_byp);

  assign ctrl_view = (16'(ramp_half_rate_select_q) << vol_pkg::HALF_RATE_BIT)
                   | (16'(done_q) << vol_pkg::DONE_BIT);
  // unmapped addresses read as zero
  assign rd_mux = sel_adc ? adc_input_gain_q :
                  sel_dac ? dac_digital_gain_q :
                  sel_byp ? line_bypass_gain_q :
                  sel_ctrl ? ctrl_view : 16'h0000;

  assign mute_req = {line_bypass_gain_q[vol_pkg::RIGHT_MUTE_BIT],
                     line_bypass_gain_q[vol_pkg::LEFT_MUTE_BIT],
                     dac_digital_gain_q[vol_pkg::RIGHT_MUTE_BIT],
                     dac_digital_gain_q[vol_pkg::LEFT_MUTE_BIT],
                     adc_input_gain_q[vol_pkg::RIGHT_MUTE_BIT],
                     adc_input_gain_q[vol_pkg::LEFT_MUTE_BIT]};
  assign code_vec = {line_bypass_gain_q[vol_pkg::RIGHT_CODE_LSB +: 7],
                     line_bypass_gain_q[vol_pkg::LEFT_CODE_LSB +: 7],
                     dac_digital_gain_q[vol_pkg::RIGHT_CODE_LSB +: 7],
                     dac_digital_gain_q[vol_pkg::LEFT_CODE_LSB +: 7],
                     adc_input_gain_q[vol_pkg::RIGHT_CODE_LSB +: 7],
                     adc_input_gain_q[vol_pkg::LEFT_CODE_LSB +: 7]};

  assign rd_data = rd_data_q;
  assign applied_gain = applied_vec;
  assign channel_muted = muted_vec;
  assign ramp_done_flag = done_q;
  assign dac_left_sample_out = dac_left_q;
  assign dac_right_sample_out = dac_right_q;

  step_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .half_rate(ramp_half_rate_select_q),
    .step(step)
  );

  // channel order: adc l, adc r, dac l, dac r, bypass l, bypass r
  genvar ch;
  generate
    for (ch = 0; ch < vol_pkg::NUM_CH; ch++) begin : g_ch
      // adc floor 07h; dac floor 00h; bypass floor 20h
      localparam logic [6:0] FLOOR = (ch < 2) ? vol_pkg::ADC_MIN_CODE :
                                     (ch < 4) ? vol_pkg::DAC_MIN_CODE :
                                     vol_pkg::BYP_MIN_CODE;
      softstep_channel #(
        .MIN_CODE(FLOOR)
      ) u_ch (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .step(step),
        .mute_req(mute_req[ch]),
        .code(code_vec[ch*7 +: 7]),
        .applied_q(applied_vec[ch*7 +: 7]),
        .muted_q(muted_vec[ch]),
        .settled_q(settled_vec[ch])
      );
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adc_input_gain_q <= vol_pkg::ADC_GAIN_RST;
      dac_digital_gain_q <= vol_pkg::DAC_GAIN_RST;
      line_bypass_gain_q <= vol_pkg::BYP_GAIN_RST;
      ramp_half_rate_select_q <= vol_pkg::HALF_RATE_RST;
    end else if (ce && wr_strobe) begin
      if (sel_adc) begin
        adc_input_gain_q <= wr_data;
      end
      if (sel_dac) begin
        dac_digital_gain_q <= wr_data;
      end
      if (sel_byp) begin
        line_bypass_gain_q <= wr_data;
      end
      if (sel_ctrl) begin
        ramp_half_rate_select_q <= wr_data[vol_pkg::HALF_RATE_BIT];
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data_q <= 16'h0000;
    end else if (ce) begin
      rd_data_q <= rd_strobe ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_q <= 1'b1;
      write_hit_q <= 1'b0;
    end else if (ce) begin
      write_hit_q <= write_hit;
      // complete only when every channel is settled
      // held low across a gain write so stale settled flags in the edge right after it never show done
      done_q <= &settled_vec & ~write_hit & ~write_hit_q;
    end
  end

  // samples pass scaled elsewhere; here a hard-muted dac feeds zeros
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dac_left_q <= 20'h00000;
      dac_right_q <= 20'h00000;
    end else if (ce) begin
      dac_left_q <= muted_vec[2] ? 20'h00000 : dac_left_sample_in;
      dac_right_q <= muted_vec[3] ? 20'h00000 : dac_right_sample_in;
    end
  end
endmodule // audio_volume_mute_softstep

/* File: sim/vol_asserts.sv */
module vol_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic rd_strobe,
  input wire logic [15:0] rd_data,
  input wire logic [41:0] applied_gain,
  input wire logic [5:0] channel_muted,
  input wire logic [19:0] dac_left_sample_out,
  input wire logic ramp_done_flag
);
  logic [10:0] gap_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // saturated at reset: no earlier tick known
  always_ff @(posedge clock) begin
    if (!rst_n) gap_q <= 11'h7ff;
    else if ($changed(applied_gain)) gap_q <= 11'h0;
    else if (gap_q != 11'h7ff) gap_q <= gap_q + 11'h1;
  end
  property p_step;
    $changed(applied_gain[6:0]) |-> (applied_gain[6:0] - $past(applied_gain[6:0]) == 7'h1)
      || ($past(applied_gain[6:0]) - applied_gain[6:0] == 7'h1);
  endproperty
  a_step: assert property (p_step) else $error("gain jumped");
  property p_gap;
    $changed(applied_gain) |-> gap_q >= 11'h31f;
  endproperty
  a_gap: assert property (p_gap) else $error("ticks too close");
  property p_adc_floor;
    channel_muted[0] |-> applied_gain[6:0] == 7'h07;
  endproperty
  a_adc_floor: assert property (p_adc_floor) else $error("adc muted off floor");
  property p_byp_floor;
    channel_muted[4] |-> applied_gain[34:28] == 7'h20;
  endproperty
  a_byp_floor: assert property (p_byp_floor) else $error("bypass muted off floor");
  property p_dac_zero;
    channel_muted[2] ##1 channel_muted[2] |-> dac_left_sample_out == 20'h0;
  endproperty
  a_dac_zero: assert property (p_dac_zero) else $error("muted dac not zero");
  property p_ctrl_rd;
    ce && rd_strobe && addr == 8'h04 |=> rd_data[15:2] == 14'h0
      && rd_data[0] == $past(ramp_done_flag);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("bad ctrl read");
  property p_rst;
    $rose(rst_n) |-> channel_muted == 6'h3f && ramp_done_flag;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_done_hold;
    ramp_done_flag && $past(ramp_done_flag) |-> $stable(applied_gain);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("gain moved while done");
  c_done: cover property ($rose(ramp_done_flag));
  c_unmute: cover property ($fell(channel_muted[0]));
  c_rd: cover property (ce && rd_strobe);
endmodule // vol_asserts
bind audio_volume_mute_softstep vol_asserts vol_asserts_i (.*);

/* File: sim/audio_volume_mute_softstep_tb.sv */
module audio_volume_mute_softstep_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, ce = 1, wr_strobe = 0, rd_strobe = 0, done;
  logic [7:0] addr = 8'h0;
  logic [15:0] wr_data = 16'h0, rd_data;
  logic [19:0] lin = 20'h0, rin = 20'h0, lin_q, rin_q, lout, rout;
  logic [41:0] gain;
  logic [5:0] muted;
  logic [6:0] c;
  int n_mismatch = 0, comparisons = 0;
  always #12.5 clock = ~clock;
  audio_volume_mute_softstep audio_volume_mute_softstep_i (.clock(clock), .rst_n(rst_n),
    .ce(ce), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .applied_gain(gain), .channel_muted(muted),
    .dac_left_sample_out(lout), .dac_right_sample_out(rout), .ramp_done_flag(done),
    .dac_left_sample_in(lin), .dac_right_sample_in(rin));
  always @(posedge clock) begin
    lin_q <= lin;
    rin_q <= rin;
    lin <= 20'($urandom);
    rin <= 20'($urandom);
  end
  function logic [6:0] ch(input int k);
    return gain[7*k +: 7];
  endfunction
  task chk(input string what, input logic [19:0] e, input logic [19:0] got);
    comparisons++;
    if (got !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1 chk("rd_data", e, rd_data);
  endtask
  task settle(input int k, input logic [6:0] e, input logic m);
    repeat (2) @(posedge clock);
    for (int i = 0; i < 20000 && done !== 1'b1; i++) @(posedge clock);
    #1 chk("gain", e, ch(k));
    chk("muted", m, muted[k]);
  endtask
  // two ticks measured so the timer phase drops out
  task gap(input int k, input int e);
    logic [6:0] v;
    int n;
    for (int j = 0; j < 2; j++) begin
      v = ch(k);
      for (n = 0; n < 4000 && ch(k) === v; n++) begin
        @(posedge clock);
        #1;
      end
    end
    chk("tick gap", e, n);
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    void'($urandom(3087));
    c = 7'h08 + 7'($urandom % 4);
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk("muted", 16'h003f, muted);
    rd(8'h01, 16'hd7d7);
    rd(8'h02, 16'hffff);
    rd(8'h03, 16'he7e7);
    rd(8'h04, 16'h0001);
    wr(8'h09, 16'hffff);
    rd(8'h09, 16'h0000);
    wr(8'h01, {1'b0, c, 8'hd7});
    repeat (2) @(posedge clock);
    #1 chk("done", 16'h0, done);
    settle(0, c, 1'b0);
    chk("adc right", 16'h0007, ch(1));
    chk("adc right muted", 16'h1, muted[1]);
    wr(8'h01, {1'b1, c, 8'hd7});
    settle(0, 7'h07, 1'b1);
    rd(8'h01, {1'b1, c, 8'hd7});
    wr(8'h01, {1'b0, c, 8'hd7});
    settle(0, c, 1'b0);
    wr(8'h01, 16'h03d7);
    settle(0, 7'h07, 1'b1);
    wr(8'h02, {1'b0, c, 8'h02});
    settle(2, c, 1'b0);
    chk("dac right", 16'h0002, ch(3));
    @(posedge clock);
    #1 chk("dac out", lin_q, lout);
    chk("dac right out", rin_q, rout);
    wr(8'h02, {1'b1, c, 8'h82});
    settle(2, 7'h00, 1'b1);
    @(posedge clock);
    #1 chk("dac out", 16'h0, lout);
    chk("dac right out", 16'h0, rout);
    wr(8'h03, 16'h2422);
    gap(4, 800);
    settle(4, 7'h24, 1'b0);
    chk("byp right", 16'h0022, ch(5));
    wr(8'h04, 16'h0002);
    rd(8'h04, 16'h0003);
    wr(8'h03, 16'ha4a2);
    gap(4, 1600);
    settle(4, 7'h20, 1'b1);
    end_of_test();
  end
endmodule // audio_volume_mute_softstep_tb
